// File: clk_sel_pkg.sv
// package for the clock source select and start-up delay block
// assumes a 100 MHz sys_clk; fuse values arrive as plain inputs
package clk_sel_pkg;
	// ==========================================================
	// clock source codes
	localparam logic [3:0] SRC_EXT = 4'h0;
	localparam logic [3:0] SRC_RC = 4'h2;
	localparam logic [3:0] SRC_LP = 4'h3;

	// ==========================================================
	// start-up select codes
	localparam logic [1:0] SUT_SHORT = 2'h0;
	localparam logic [1:0] SUT_FAST = 2'h1;
	localparam logic [1:0] SUT_SLOW = 2'h2;

	// ==========================================================
	// register map
	localparam logic [1:0] ADDR_TRIM = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam int TRIM_RANGE_BIT = 7;
	localparam logic [7:0] TRIM_RESET = 8'h80;

	// ==========================================================
	// timing: cycles of selected clock, then millisecond waits
	localparam int CLK_HZ = 100000000;
	localparam logic [4:0] WAKE_CK = 5'h06;
	localparam logic [4:0] RESET_CK = 5'h0e;
	localparam int MS_4P1_US = 4100;
	localparam int MS_4_US = 4000;
	localparam int MS_65_US = 65000;
	localparam int MS_64_US = 64000;
	localparam int MS_4P1_CYC = MS_4P1_US * (CLK_HZ / 1000000);
	localparam int MS_4_CYC = MS_4_US * (CLK_HZ / 1000000);
	localparam int MS_65_CYC = MS_65_US * (CLK_HZ / 1000000);
	localparam int MS_64_CYC = MS_64_US * (CLK_HZ / 1000000);

	// ==========================================================
	// types
	typedef struct packed {
		logic [3:0] clock_source_select;
		logic [1:0] startup_time_select;
		logic divide_by_eight_fuse;
		logic reset_pin_disable_fuse;
	} fuse_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// File: clock_source_startup_select.sv
// clock source select, start-up delay and rc trim register
// assumes fuses are stable, source ticks come pre-synchronised as one-cycle enables
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - fuse code 0010 selects the calibrated internal rc oscillator
// - every reset loads the factory calibration byte into the trim register
// - watchdog and reset timeout stay on the separate watchdog oscillator
// - rc source: wake 6 ck, reset 14 ck plus 0, 4.1 or 65 ms
// - reset pin disable fuse stretches the short reset delay by 4.1 ms
// - software reads and writes the trim register; writes act at once
// - trim bit 7 picks low or high overlapping range
// - seven fine bits tune monotonically from 0x00 to 0x7f
// - fuse code 0011 selects the 128 kHz low power oscillator
// - 128 kHz source: wake 6 ck, reset 14 ck plus 0, 4 or 64 ms
// - fuse code 0000 selects the external clock input
// - external source: wake 6 ck, reset 14 ck plus 0, 4.1 or 65 ms
// - divide by eight fuse divides the selected clock by eight
module clock_source_startup_select
	import clk_sel_pkg::*;
(
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// fuses and calibration
	input wire clk_sel_pkg::fuse_t fuses,
	input wire logic [7:0] factory_cal,
	// source ticks and watchdog tick
	input wire logic rc_tick,
	input wire logic lp_tick,
	input wire logic ext_tick,
	input wire logic wdt_tick,
	// power-down or power-save wake request
	input wire logic wake_req,
	// register port
	input wire clk_sel_pkg::reg_req_t reg_req,
	output logic [7:0] rd_data,
	// clock outputs
	output logic core_tick,
	output logic clock_ready,
	output logic [7:0] rc_trim,
	output logic bad_select
);
	import clk_sel_pkg::*;

	// ==========================================================
	// state
	typedef enum logic [1:0] {
		ST_COUNT = 2'b00,
		ST_MS = 2'b01,
		ST_RUN = 2'b10
	} state_t;

	state_t state_r;
	state_t state_nxt;
	logic [7:0] trim_r;
	logic [7:0] rd_data_r;
	logic [4:0] ck_cnt_r;
	logic [4:0] ck_cnt_nxt;
	logic [22:0] ms_cnt_r;
	logic [22:0] ms_cnt_nxt;
	logic [2:0] div_r;
	logic core_tick_r;
	logic ready_r;
	logic bad_r;
	logic cal_pend_r;
	logic wake_r;

	// ==========================================================
	// source selection
	wire sel_rc = fuses.clock_source_select == SRC_RC;
	wire sel_lp = fuses.clock_source_select == SRC_LP;
	wire sel_ext = fuses.clock_source_select == SRC_EXT;
	wire sel_ok = sel_rc | sel_lp | sel_ext;
	wire src_tick = (sel_rc & rc_tick) | (sel_lp & lp_tick) | (sel_ext & ext_tick);
	wire sut_bad = fuses.startup_time_select == 2'h3;

	// millisecond part of the reset delay, timed by watchdog ticks
	// so it stays correct whatever source is chosen
	logic [22:0] ms_target;
	always_comb
	begin
		unique case (fuses.startup_time_select)
			SUT_SHORT: ms_target = fuses.reset_pin_disable_fuse ?
				23'(MS_4P1_CYC) : 23'h0;
			SUT_FAST: ms_target = sel_lp ? 23'(MS_4_CYC) : 23'(MS_4P1_CYC);
			SUT_SLOW: ms_target = sel_lp ? 23'(MS_64_CYC) : 23'(MS_65_CYC);
			default: ms_target = 23'h0;
		endcase
	end

	// ==========================================================
	// start-up sequencer; sys_clk stands in for the watchdog oscillator
	// count, a wdt_tick low means that time simply stalls
	wire ck_done = ck_cnt_r == 5'h01 && src_tick;
	// a wake from power-down or power-save never adds the millisecond part
	wire [22:0] ms_load = wake_r ? 23'h0 : ms_target;
	always_comb
	begin
		state_nxt = state_r;
		ck_cnt_nxt = ck_cnt_r;
		ms_cnt_nxt = ms_cnt_r;
		unique case (state_r)
			ST_COUNT:
			begin
				if (src_tick)
					ck_cnt_nxt = ck_cnt_r - 5'h01;
				if (ck_done)
					state_nxt = (ms_load == 23'h0) ? ST_RUN : ST_MS;
			end
			ST_MS:
			begin
				if (wdt_tick)
					ms_cnt_nxt = ms_cnt_r - 23'h1;
				if (ms_cnt_r == 23'h1 && wdt_tick)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (wake_req)
				begin
					state_nxt = ST_COUNT;
					ck_cnt_nxt = WAKE_CK;
					ms_cnt_nxt = 23'h0;
				end
			end
			default: state_nxt = ST_COUNT;
		endcase
	end

	// ==========================================================
	// register decode
	wire wr_trim = reg_req.wr && reg_req.addr == ADDR_TRIM;
	wire [7:0] rd_mux = (reg_req.addr == ADDR_TRIM) ? trim_r :
		(reg_req.addr == ADDR_STATUS) ? {6'h0, bad_r, ready_r} : 8'h00;

	// core clock gated until ready, optional divide by eight
	wire div_wrap = div_r == 3'h7;
	wire tick_pass = ready_r && src_tick &&
		(!fuses.divide_by_eight_fuse || div_wrap);

	// sequencer registers; reset starts the 14 ck plus ms delay
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_r <= ST_COUNT;
			ck_cnt_r <= RESET_CK;
			ms_cnt_r <= 23'h0;
			wake_r <= 1'b0;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			ck_cnt_r <= ck_cnt_nxt;
			ms_cnt_r <= (state_r == ST_COUNT && state_nxt == ST_MS) ? ms_load : ms_cnt_nxt;
			wake_r <= wake_r | (state_r == ST_RUN && wake_req);
		end
	end

	// trim register: calibration copied in on every reset
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			trim_r <= TRIM_RESET;
			cal_pend_r <= 1'b1;
		end
		else if (clk_en)
		begin
			cal_pend_r <= 1'b0;
			if (cal_pend_r)
				trim_r <= factory_cal;
			else if (wr_trim)
				trim_r <= reg_req.wdata;
		end
	end

	// outputs and read data, all registered
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			div_r <= 3'h0;
			core_tick_r <= 1'b0;
			ready_r <= 1'b0;
			bad_r <= 1'b0;
			rd_data_r <= 8'h00;
		end
		else if (clk_en)
		begin
			if (ready_r && src_tick)
				div_r <= div_r + 3'h1;
			core_tick_r <= tick_pass;
			ready_r <= state_nxt == ST_RUN;
			bad_r <= !sel_ok || sut_bad;
			rd_data_r <= reg_req.rd ? rd_mux : 8'h00;
		end
	end

	assign rd_data = rd_data_r;
	assign core_tick = core_tick_r;
	assign clock_ready = ready_r;
	assign rc_trim = trim_r; // drives oscillator directly
	assign bad_select = bad_r;
endmodule // clock_source_startup_select

`default_nettype wire

// File: tick_src.sv
// far-side clock source model: one-cycle tick every PER cycles
// assumes a free sys_clk
`timescale 1ns/1ps
`default_nettype none
module tick_src #(parameter int PER = 4) (
	input wire logic sys_clk,
	output logic tick
);
	// ==========
	int cnt_r = 0;
	initial tick = 1'b0;
	// fixed period: no cycle-to-cycle jump
	always @(posedge sys_clk)
	begin
		cnt_r <= (cnt_r == PER - 1) ? 0 : cnt_r + 1;
		tick <= (cnt_r == PER - 1);
	end
endmodule // tick_src
`default_nettype wire

// File: clk_sel_chk.sv
// port checker for the clock select block
// assumes bind into clock_source_startup_select
`timescale 1ns/1ps
`default_nettype none
module clk_sel_chk
	import clk_sel_pkg::*;
(
	input wire logic sys_clk, rst, clk_en, rc_tick, lp_tick, ext_tick, wake_req,
	input wire fuse_t fuses,
	input wire reg_req_t reg_req,
	input wire logic [7:0] factory_cal, rd_data, rc_trim,
	input wire logic core_tick, clock_ready, bad_select
);
	// ==========
	// selected tick; ticks seen while not ready
	wire logic st = (fuses.clock_source_select == SRC_RC) ? rc_tick :
		(fuses.clock_source_select == SRC_LP) ? lp_tick : ext_tick;
	logic [4:0] n_r;
	logic wk_r;
	always_ff @(posedge sys_clk)
	begin
		n_r <= (rst || clock_ready) ? 5'h00 : n_r + 5'(st);
		wk_r <= rst ? 1'b0 : ((wake_req && clock_ready) ? 1'b1 : wk_r);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	start_count_a: assert property (
		$rose(clock_ready) && fuses.startup_time_select == SUT_SHORT && !fuses.reset_pin_disable_fuse
		|-> n_r == (wk_r ? WAKE_CK : RESET_CK)) else $error("start count wrong");
	gate_off_a: assert property (
		!$past(clock_ready) |-> !core_tick) else $error("tick while gated");
	tick_pass_a: assert property (
		!fuses.divide_by_eight_fuse && $past(clock_ready) |-> core_tick == $past(st))
		else $error("core tick not source");
	wake_drop_a: assert property (
		wake_req && clock_ready && clk_en |=> !clock_ready) else $error("ready kept");
	cal_load_a: assert property (
		$past(rst) && clk_en |=> rc_trim == $past(factory_cal)) else $error("no cal load");
	trim_write_a: assert property (
		reg_req.wr && reg_req.addr == ADDR_TRIM && clk_en && !$past(rst)
		|=> rc_trim == $past(reg_req.wdata)) else $error("trim write lost");
	trim_read_a: assert property (
		reg_req.rd && reg_req.addr == ADDR_TRIM |=> rd_data == $past(rc_trim))
		else $error("trim read wrong");
	stat_read_a: assert property (
		reg_req.rd && reg_req.addr == ADDR_STATUS
		|=> rd_data == {6'h00, $past(bad_select), $past(clock_ready)}) else $error("status wrong");
	idle_read_a: assert property (
		!reg_req.rd || reg_req.addr > ADDR_STATUS |=> rd_data == 8'h00) else $error("rd not 0");
	bad_code_a: assert property (
		fuses.startup_time_select == 2'h3 |-> ##[1:2] bad_select) else $error("no bad flag");
	cover property ($rose(clock_ready) && wk_r);
	cover property (core_tick && fuses.divide_by_eight_fuse);
	cover property ($rose(bad_select));
endmodule // clk_sel_chk
bind clock_source_startup_select clk_sel_chk i_clk_sel_chk (.*);
`default_nettype wire

// File: tb_top.sv
// bench for the clock select block
// assumes tick_src models and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import clk_sel_pkg::*;
	// ==========
	logic sys_clk = 1'b0, rst = 1'b1, wake_req = 1'b0, core_tick, clock_ready, bad_select;
	logic rc_tick, lp_tick, ext_tick;
	logic [7:0] rd_data, rc_trim, cal = 8'h5a;
	fuse_t fuses = '{SRC_RC, SUT_SHORT, 1'b0, 1'b0};
	reg_req_t req = '0;
	int fails = 0, cmp_count = 0, cyc = 0;
	wire logic st = (fuses.clock_source_select == SRC_LP) ? lp_tick :
		(fuses.clock_source_select == SRC_EXT) ? ext_tick : rc_tick;
	always #5 sys_clk = ~sys_clk;
	tick_src #(.PER(3)) i_rc (.sys_clk, .tick(rc_tick));
	tick_src #(.PER(5)) i_lp (.sys_clk, .tick(lp_tick));
	tick_src #(.PER(4)) i_ext (.sys_clk, .tick(ext_tick));
	clock_source_startup_select i_clock_source_startup_select (.sys_clk, .rst, .clk_en(1'b1),
		.fuses, .factory_cal(cal), .rc_tick, .lp_tick, .ext_tick, .wdt_tick(1'b1), .wake_req,
		.reg_req(req), .rd_data, .core_tick, .clock_ready, .rc_trim, .bad_select);
	task summarize();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk)
		if (++cyc == 20000)
		begin
			fails++;
			summarize();
		end
	task chk(input logic [7:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk) req <= '0;
		#1 chk(rd_data, e);
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d, e);
		@(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk) req <= '0;
		#1 chk(rc_trim, e);
	endtask
	// ticks seen until ready, then compared
	task cnt_ready(input logic [4:0] e);
		int n;
		n = 0;
		for (int i = 0; i < 300; i++)
		begin
			#1;
			if (clock_ready === 1'b1)
				break;
			n += int'(st);
			@(posedge sys_clk);
		end
		chk(8'(n), {3'h0, e});
	endtask
	task boot(input logic [3:0] s, input logic d, input logic [1:0] t);
		@(posedge sys_clk);
		fuses <= '{s, t, d, 1'b0};
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		if (t == SUT_SHORT && s != 4'h1)
			cnt_ready(RESET_CK);
		$display("boot %h done", s);
	endtask
	// wake just after a tick so no tick shares the wake edge
	task wake();
		do
			@(posedge sys_clk) #1;
		while (st !== 1'b1);
		@(posedge sys_clk) wake_req <= 1'b1;
		@(posedge sys_clk) wake_req <= 1'b0;
		cnt_ready(WAKE_CK);
		$display("wake done");
	endtask
	// core ticks against source ticks, one divider step of slack
	task ratio(input int r);
		int s, c;
		s = 0;
		c = 0;
		repeat (240)
		begin
			@(posedge sys_clk) #1 s += int'(st);
			c += int'(core_tick);
		end
		chk({7'h0, c * r + r >= s && c * r <= s + r}, 8'h01);
		$display("ratio done");
	endtask
	initial
	begin
		boot(SRC_RC, 1'b0, SUT_SHORT);
		rd(ADDR_TRIM, 8'h5a);
		ratio(1);
		wake();
		wr(ADDR_TRIM, 8'h7f, 8'h7f);
		rd(ADDR_TRIM, 8'h7f);
		wr(ADDR_TRIM, 8'h80, 8'h80);
		wr(2'h3, 8'h11, 8'h80);
		rd(2'h2, 8'h00);
		rd(ADDR_STATUS, 8'h01);
		cal = 8'h3c;
		boot(SRC_LP, 1'b0, SUT_SHORT);
		rd(ADDR_TRIM, 8'h3c);
		ratio(1);
		wake();
		boot(SRC_EXT, 1'b1, SUT_SHORT);
		ratio(8);
		wake();
		boot(SRC_RC, 1'b0, SUT_FAST);
		repeat (200) @(posedge sys_clk);
		#1 chk({7'h0, clock_ready}, 8'h00);
		boot(SRC_RC, 1'b0, 2'h3);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h0, bad_select}, 8'h01);
		boot(4'h1, 1'b0, SUT_SHORT);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h0, bad_select}, 8'h01);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
